//--- rtl/ifsc_pkg.sv
// Purpose: shared constants and types of the input fault scan configuration block
// Assumes: 10 MHz clock, registers in byte lane 0 of a 32-bit Avalon-MM word
// Notes:   byte address of a register is four times its index
package ifsc_pkg;

  // ==========================================================================
  // register indices
  localparam logic [7:0] IDX_SCAN_TIMING = 8'h67;
  localparam logic [7:0] IDX_AVERAGE     = 8'h68;
  localparam logic [7:0] IDX_BIAS        = 8'h6A;
  localparam logic [7:0] IDX_SIGPATH     = 8'h6B;
  localparam logic [7:0] IDX_CTRL        = 8'h7C;
  localparam logic [7:0] IDX_FAULT       = 8'h7D;
  localparam logic [7:0] IDX_IRQ_STAT    = 8'h7E;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h7F;

  // ==========================================================================
  // reset values and writable masks
  localparam logic [7:0] RST_SCAN_TIMING = 8'hB8;
  localparam logic [7:0] RST_AVERAGE     = 8'h00;
  localparam logic [7:0] RST_BIAS        = 8'h00;
  localparam logic [7:0] RST_SIGPATH     = 8'h01;
  localparam logic [7:0] RST_CTRL        = 8'h03;
  localparam logic [7:0] RST_IRQ_MASK    = 8'h00;
  localparam logic [7:0] WR_SCAN_TIMING  = 8'hFF;
  localparam logic [7:0] WR_AVERAGE      = 8'hF0;
  localparam logic [7:0] WR_BIAS         = 8'hF8;
  localparam logic [7:0] WR_SIGPATH      = 8'h3F;
  localparam logic [7:0] WR_CTRL         = 8'h8F;

  // ==========================================================================
  // field positions
  localparam int SCAN_RATE_LSB     = 6;
  localparam int FILT_SEL_LSB      = 2;
  localparam int SUPPLY_FILT_BIT   = 1;
  localparam int DOUBLE_BIT        = 0;
  localparam int AVG_SEL_LSB       = 6;
  localparam int LOAD_AVG_OFF_BIT  = 5;
  localparam int TEMP_AVG_OFF_BIT  = 4;
  localparam int BYPASS_BIT        = 7;
  localparam int SCAN_EN_BIT       = 7;
  localparam int TERM_THR_LSB      = 0;
  localparam int IRQ_SCAN_DONE_BIT = 5;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ          = 10;
  localparam int INTERVAL_A_US    = 1000;
  localparam int INTERVAL_B_US    = 4000;
  localparam int INTERVAL_C_US    = 8000;
  localparam int INTERVAL_A_CYC   = INTERVAL_A_US * CLK_MHZ;
  localparam int INTERVAL_B_CYC   = INTERVAL_B_US * CLK_MHZ;
  localparam int INTERVAL_C_CYC   = INTERVAL_C_US * CLK_MHZ;
  localparam int TIMER_W          = 17;

  // ==========================================================================
  // fault filter
  localparam int         NUM_FAULTS   = 5;
  localparam int         FLT_SUPPLY   = 0;
  localparam int         CNT_W        = 5;
  localparam logic [4:0] FILT_CNT_16  = 5'h10;
  localparam logic [4:0] FILT_CNT_8   = 5'h08;
  localparam logic [4:0] FILT_CNT_4   = 5'h04;
  localparam logic [4:0] FILT_CNT_0   = 5'h01;

  // ==========================================================================
  // thresholds and levels
  localparam logic [9:0] THRESH_STEP_MV = 10'h01E;
  localparam int         LEVEL_W        = 12;

  typedef enum logic [1:0] {
    AVG_OFF   = 2'b00,
    AVG_HALF  = 2'b01,
    AVG_QUART = 2'b10,
    AVG_RSVD  = 2'b11
  } ifsc_avg_mode_t;

  typedef enum logic [0:0] {
    SCAN_IDLE = 1'b0,
    SCAN_BUSY = 1'b1
  } ifsc_scan_state_t;

endpackage : ifsc_pkg

//--- rtl/ifsc_filt_if.sv
// Purpose: link between the scan controller and one fault filter
// Assumes: one filter per fault type
// Notes:   scan_done marks the scan whose result is on detect
`timescale 1ns/1ps
interface ifsc_filt_if;
  import ifsc_pkg::*;
  logic              scan_done;
  logic              detect;
  logic [CNT_W-1:0]  limit;
  logic              fault;

  modport owner  (output scan_done, output detect, output limit, input fault);
  modport filter (input scan_done, input detect, input limit, output fault);
endinterface : ifsc_filt_if

//--- rtl/ifsc_fault_filter.sv
// Purpose: consecutive-scan debounce of one fault condition
// Assumes: limit is at least one
// Notes:   a clean scan drops both count and reported fault
`timescale 1ns/1ps
module ifsc_fault_filter (
  input  wire logic   CLK,     // block clock
  input  wire logic   RESETN,  // async reset, active low
  ifsc_filt_if.filter f        // scan result in, fault out
);
  import ifsc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             fault_r;
  logic             fault_nxt;

  // ==========================================================================
  // count detections, clean scan restarts
  assign cnt_nxt   = !f.scan_done ? cnt_r :
                     !f.detect    ? '0 :
                     (cnt_r >= f.limit) ? cnt_r : cnt_r + 1'b1;
  assign fault_nxt = !f.scan_done ? fault_r :
                     (f.detect && (cnt_r + 1'b1 >= f.limit));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r   <= '0;
      fault_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign f.fault = fault_r;

endmodule : ifsc_fault_filter

//--- rtl/ifsc_top.sv
// Purpose: configuration registers and control of the input fault scanner
// Assumes: analog scan front end answers each SCAN_START with one SCAN_DONE
// Notes:   Avalon-MM slave, one wait state on every access
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - Scan interval codes 1, 2 and 3 repeat the scan every 1 ms, 4 ms and 8 ms.
// - Scan interval code 0 starts each scan right as the previous one finishes.
// - Faults other than the low-supply battery short debounce 16, 8, 4 or no counts for codes 0 to 3.
// - With battery below bias, the battery short debounces 16 counts for bit 0 and 8 for bit 1.
// - The scale bit doubles every detection threshold, clear leaves them unchanged.
// - Averaging code 0 is off, 1 weights old and new half each, 2 weights old three quarters.
// - The bias load override bit turns averaging off for bias load current detection.
// - The temperature override bit turns averaging off for over-temperature detection.
// - Boost runs when the bypass bit is 0 and is bypassed when it is 1.
// - After reset the scan interval field reads 10b and the debounce select field 10b.
// - The terminal short threshold code steps 30 mV from 0 mV at code 0 to 450 mV at code 15.
module ifsc_top #(
  parameter int INTERVAL_A = ifsc_pkg::INTERVAL_A_CYC,  // 1 ms in cycles
  parameter int INTERVAL_B = ifsc_pkg::INTERVAL_B_CYC,  // 4 ms in cycles
  parameter int INTERVAL_C = ifsc_pkg::INTERVAL_C_CYC   // 8 ms in cycles
) (
  input  wire logic                               CLK,              // 10 MHz clock
  input  wire logic                               RESETN,           // async reset, active low
  input  wire logic [8:0]                         ADDRESS,          // byte address
  input  wire logic                               READ,             // read request
  input  wire logic                               WRITE,            // write request
  input  wire logic [31:0]                        WRITEDATA,        // write data
  input  wire logic [3:0]                         BYTEENABLE,       // byte lanes
  output logic      [31:0]                        READDATA,         // read data
  output logic                                    WAITREQUEST,      // stall
  output logic                                    IRQ,              // level interrupt
  output logic                                    SCAN_START,       // one-cycle scan kick
  input  wire logic                               SCAN_DONE,        // scan finished pulse
  input  wire logic [ifsc_pkg::NUM_FAULTS-1:0]    FAULT_DETECT,     // raw per-scan detections
  input  wire logic                               VBAT_BELOW_BIAS,  // battery below bias level
  input  wire logic [ifsc_pkg::LEVEL_W-1:0]       GEN_LEVEL,        // general scan level
  input  wire logic [ifsc_pkg::LEVEL_W-1:0]       LOAD_LEVEL,       // bias load current level
  input  wire logic [ifsc_pkg::LEVEL_W-1:0]       TEMP_LEVEL,       // temperature level
  output logic      [ifsc_pkg::LEVEL_W-1:0]       GEN_AVG,          // averaged general level
  output logic      [ifsc_pkg::LEVEL_W-1:0]       LOAD_AVG,         // averaged load level
  output logic      [ifsc_pkg::LEVEL_W-1:0]       TEMP_AVG,         // averaged temperature level
  output logic      [ifsc_pkg::NUM_FAULTS-1:0]    FAULT_FLAGS,      // debounced faults
  output logic      [10:0]                        TERM_THRESH_MV,   // terminal short threshold
  output logic                                    THRESH_SCALE,     // thresholds doubled
  output logic                                    BOOST_ENABLE,     // bias boost running
  output logic      [7:0]                         SIGPATH_CFG       // signal path config
);
  import ifsc_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0]            timing_r;
  logic [7:0]            average_r;
  logic [7:0]            bias_r;
  logic [7:0]            sigpath_r;
  logic [7:0]            ctrl_r;
  logic [7:0]            irq_stat_r;
  logic [7:0]            irq_stat_nxt;
  logic [7:0]            irq_mask_r;
  logic                  ack_r;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;

  // ==========================================================================
  // bus decode
  wire                   req       = READ | WRITE;
  wire                   aligned   = (ADDRESS[1:0] == 2'b00);
  wire  [7:0]            idx       = {1'b0, ADDRESS[8:2]};
  wire                   sel_tim   = aligned && (idx == IDX_SCAN_TIMING);
  wire                   sel_avg   = aligned && (idx == IDX_AVERAGE);
  wire                   sel_bias  = aligned && (idx == IDX_BIAS);
  wire                   sel_sig   = aligned && (idx == IDX_SIGPATH);
  wire                   sel_ctrl  = aligned && (idx == IDX_CTRL);
  wire                   sel_flt   = aligned && (idx == IDX_FAULT);
  wire                   sel_stat  = aligned && (idx == IDX_IRQ_STAT);
  wire                   sel_mask  = aligned && (idx == IDX_IRQ_MASK);
  // a write lands only at the edge where WAITREQUEST is low
  wire                   wr_go     = WRITE && ack_r && BYTEENABLE[0];
  wire  [7:0]            wd        = WRITEDATA[7:0];
  wire  [7:0]            fault_vec = {{(8-NUM_FAULTS){1'b0}}, FAULT_FLAGS};

  // unmapped addresses read zero and ignore writes
  assign rdata_nxt = sel_tim  ? {24'h000000, timing_r}   :
                     sel_avg  ? {24'h000000, average_r}  :
                     sel_bias ? {24'h000000, bias_r}     :
                     sel_sig  ? {24'h000000, sigpath_r}  :
                     sel_ctrl ? {24'h000000, ctrl_r}     :
                     sel_flt  ? {24'h000000, fault_vec}  :
                     sel_stat ? {24'h000000, irq_stat_r} :
                     sel_mask ? {24'h000000, irq_mask_r} : 32'h00000000;

  assign WAITREQUEST = req && !ack_r;
  assign READDATA    = rdata_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= req && !ack_r;
      rdata_r <= (READ && !ack_r) ? rdata_nxt : rdata_r;
    end
  end

  // ==========================================================================
  // configuration registers
  // reserved fields of the average, bias, signal path and control registers are cleared by the write masks; scan timing and interrupt mask store every bit written
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      timing_r   <= RST_SCAN_TIMING;
      average_r  <= RST_AVERAGE;
      bias_r     <= RST_BIAS;
      sigpath_r  <= RST_SIGPATH;
      ctrl_r     <= RST_CTRL;
      irq_mask_r <= RST_IRQ_MASK;
    end else begin
      if (wr_go && sel_tim) begin
        timing_r <= wd & WR_SCAN_TIMING;
      end
      if (wr_go && sel_avg) begin
        average_r <= wd & WR_AVERAGE;
      end
      if (wr_go && sel_bias) begin
        bias_r <= wd & WR_BIAS;
      end
      if (wr_go && sel_sig) begin
        sigpath_r <= wd & WR_SIGPATH;
      end
      if (wr_go && sel_ctrl) begin
        ctrl_r <= wd & WR_CTRL;
      end
      if (wr_go && sel_mask) begin
        irq_mask_r <= wd;
      end
    end
  end

  // ==========================================================================
  // field extraction
  wire  [1:0]            rate_sel   = timing_r[SCAN_RATE_LSB +: 2];
  wire  [1:0]            filt_sel   = timing_r[FILT_SEL_LSB +: 2];
  wire                   supply_sel = timing_r[SUPPLY_FILT_BIT];
  wire                   dbl        = timing_r[DOUBLE_BIT];
  wire                   scan_en    = ctrl_r[SCAN_EN_BIT];
  wire  [3:0]            term_code  = ctrl_r[TERM_THR_LSB +: 4];
  ifsc_avg_mode_t        avg_mode;
  assign avg_mode = ifsc_avg_mode_t'(average_r[AVG_SEL_LSB +: 2]);

  // ==========================================================================
  // scan repetition
  ifsc_scan_state_t      state_r;
  ifsc_scan_state_t      state_nxt;
  logic [TIMER_W-1:0]    timer_r;
  logic [TIMER_W-1:0]    timer_nxt;
  logic                  scan_start_r;
  logic [TIMER_W-1:0]    period;

  assign period = (rate_sel == 2'd1) ? TIMER_W'(INTERVAL_A) :
                  (rate_sel == 2'd2) ? TIMER_W'(INTERVAL_B) :
                                       TIMER_W'(INTERVAL_C);

  // interval measured start to start; an overlong scan starts the next at once
  wire                   due      = (rate_sel == 2'd0) || (timer_r >= period);
  wire                   go_idle  = (state_r == SCAN_IDLE) && due;
  // continuous mode chains straight off the finishing scan
  wire                   go_chain = (state_r == SCAN_BUSY) && SCAN_DONE && (rate_sel == 2'd0);
  wire                   start_go = scan_en && (go_idle || go_chain);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SCAN_IDLE: begin
        if (start_go) begin
          state_nxt = SCAN_BUSY;
        end
      end
      SCAN_BUSY: begin
        if (SCAN_DONE && !start_go) begin
          state_nxt = SCAN_IDLE;
        end
      end
      default: begin
        state_nxt = SCAN_IDLE;
      end
    endcase
  end

  assign timer_nxt = start_go ? {{(TIMER_W-1){1'b0}}, 1'b1} :
                     (timer_r >= period) ? timer_r : timer_r + 1'b1;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r      <= SCAN_IDLE;
      timer_r      <= '0;
      scan_start_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      timer_r      <= timer_nxt;
      scan_start_r <= start_go;
    end
  end

  assign SCAN_START = scan_start_r;

  // ==========================================================================
  // fault debounce
  logic [CNT_W-1:0]      gen_limit;
  logic [CNT_W-1:0]      supply_limit;

  assign gen_limit = (filt_sel == 2'd0) ? FILT_CNT_16 :
                     (filt_sel == 2'd1) ? FILT_CNT_8  :
                     (filt_sel == 2'd2) ? FILT_CNT_4  :
                                          FILT_CNT_0;
  // battery short has its own filter only while battery sits below bias
  assign supply_limit = !VBAT_BELOW_BIAS ? gen_limit :
                        supply_sel       ? FILT_CNT_8 : FILT_CNT_16;

  // only done pulses of a scan this block started count
  wire                   done_ok = SCAN_DONE && (state_r == SCAN_BUSY);

  ifsc_filt_if           filt_link [NUM_FAULTS] ();

  generate
    for (genvar g = 0; g < NUM_FAULTS; g++) begin : g_filt
      assign filt_link[g].scan_done = done_ok;
      assign filt_link[g].detect    = FAULT_DETECT[g];
      assign filt_link[g].limit     = (g == FLT_SUPPLY) ? supply_limit : gen_limit;
      assign FAULT_FLAGS[g]         = filt_link[g].fault;
      ifsc_fault_filter u_filt (
        .CLK    (CLK),
        .RESETN (RESETN),
        .f      (filt_link[g])
      );
    end
  endgenerate

  // ==========================================================================
  // moving average
  function automatic logic [LEVEL_W-1:0] avg_step(
    input ifsc_avg_mode_t     mode,
    input logic               off,
    input logic [LEVEL_W-1:0] old_v,
    input logic [LEVEL_W-1:0] new_v
  );
    logic [LEVEL_W+1:0] sum;
    sum = '0;
    if (off || mode == AVG_OFF || mode == AVG_RSVD) begin
      avg_step = new_v;
    end else if (mode == AVG_HALF) begin
      sum      = {2'b00, old_v} + {2'b00, new_v};
      avg_step = sum[LEVEL_W:1];
    end else begin
      sum      = {1'b0, old_v, 1'b0} + {2'b00, old_v} + {2'b00, new_v};
      avg_step = sum[LEVEL_W+1:2];
    end
  endfunction

  logic [LEVEL_W-1:0]    gen_avg_r;
  logic [LEVEL_W-1:0]    load_avg_r;
  logic [LEVEL_W-1:0]    temp_avg_r;

  wire  [LEVEL_W-1:0]    gen_avg_nxt  = avg_step(avg_mode, 1'b0, gen_avg_r, GEN_LEVEL);
  wire  [LEVEL_W-1:0]    load_avg_nxt = avg_step(avg_mode, average_r[LOAD_AVG_OFF_BIT],
                                                 load_avg_r, LOAD_LEVEL);
  wire  [LEVEL_W-1:0]    temp_avg_nxt = avg_step(avg_mode, average_r[TEMP_AVG_OFF_BIT],
                                                 temp_avg_r, TEMP_LEVEL);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      gen_avg_r  <= '0;
      load_avg_r <= '0;
      temp_avg_r <= '0;
    end else if (done_ok) begin
      gen_avg_r  <= gen_avg_nxt;
      load_avg_r <= load_avg_nxt;
      temp_avg_r <= temp_avg_nxt;
    end
  end

  assign GEN_AVG  = gen_avg_r;
  assign LOAD_AVG = load_avg_r;
  assign TEMP_AVG = temp_avg_r;

  // ==========================================================================
  // thresholds, boost, signal path
  logic [10:0]           term_thr_r;
  wire  [9:0]            term_base = 10'(term_code * THRESH_STEP_MV);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      term_thr_r <= '0;
    end else begin
      term_thr_r <= dbl ? {term_base, 1'b0} : {1'b0, term_base};
    end
  end

  assign TERM_THRESH_MV = term_thr_r;
  assign THRESH_SCALE   = dbl;
  assign BOOST_ENABLE   = !bias_r[BYPASS_BIT];
  assign SIGPATH_CFG    = sigpath_r;

  // ==========================================================================
  // interrupts
  logic [NUM_FAULTS-1:0] flags_q;
  wire  [NUM_FAULTS-1:0] flag_rise = FAULT_FLAGS & ~flags_q;
  wire  [7:0]            irq_set   = {2'b00, done_ok, flag_rise};
  wire  [7:0]            irq_clr   = (wr_go && sel_stat) ? wd : 8'h00;

  // a new event beats a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_stat_r <= 8'h00;
      flags_q    <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      flags_q    <= FAULT_FLAGS;
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

endmodule : ifsc_top

//--- bench/ifsc_top_asserts.sv
// Purpose: port checks of the fault scan configuration block
// Assumes: lane-0 writes are shadowed here
// Notes:   busy_r mirrors the scan state seen at the ports
`timescale 1ns/1ps
module ifsc_top_asserts (
  input wire logic        CLK,            // clock
  input wire logic        RESETN,         // reset, active low
  input wire logic [8:0]  ADDRESS,        // byte address
  input wire logic        WRITE,          // write request
  input wire logic [31:0] WRITEDATA,      // write data
  input wire logic [3:0]  BYTEENABLE,     // lanes
  input wire logic        WAITREQUEST,    // stall
  input wire logic        SCAN_START,     // scan kick
  input wire logic        SCAN_DONE,      // scan end
  input wire logic [4:0]  FAULT_DETECT,   // raw detections
  input wire logic [11:0] GEN_LEVEL,      // general level
  input wire logic [11:0] LOAD_LEVEL,     // load level
  input wire logic [11:0] TEMP_LEVEL,     // temperature level
  input wire logic [11:0] GEN_AVG,        // general average
  input wire logic [11:0] LOAD_AVG,       // load average
  input wire logic [11:0] TEMP_AVG,       // temperature average
  input wire logic [4:0]  FAULT_FLAGS,    // debounced faults
  input wire logic [10:0] TERM_THRESH_MV, // threshold
  input wire logic        THRESH_SCALE,   // doubling
  input wire logic        BOOST_ENABLE    // boost on
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ==========
  // register shadows
  logic       busy_r, en_r;
  logic [7:0] tim_r, avg_r;
  wire        wr_ok = WRITE & ~WAITREQUEST & BYTEENABLE[0];
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_r <= 1'b0;
      en_r   <= 1'b0;
      tim_r  <= 8'hB8;
      avg_r  <= 8'h00;
    end else begin
      busy_r <= SCAN_START | (busy_r & ~SCAN_DONE);
      if (wr_ok && ADDRESS == 9'h1F0) en_r <= WRITEDATA[7];
      if (wr_ok && ADDRESS == 9'h19C) tim_r <= WRITEDATA[7:0];
      if (wr_ok && ADDRESS == 9'h1A0) avg_r <= WRITEDATA[7:0];
    end
  end
  // ==========
  // properties
  sequence s_done;
    SCAN_DONE && busy_r;
  endsequence
  sequence s_ctrl_wr;
    wr_ok && ADDRESS == 9'h1F0;
  endsequence
  a_start_pulse: assert property (SCAN_START |=> !SCAN_START)
    else $error("scan start held too long");
  a_back_to_back: assert property (s_done ##0 (en_r && tim_r[7:6] == 2'b00) |=> SCAN_START)
    else $error("continuous scan did not restart");
  a_clean_clears: assert property (s_done |=> (FAULT_FLAGS & ~$past(FAULT_DETECT)) == 5'h00)
    else $error("fault flag without detection");
  a_scale_bit: assert property (wr_ok && ADDRESS == 9'h19C |=> THRESH_SCALE == $past(WRITEDATA[0]))
    else $error("scale output wrong");
  a_boost_bit: assert property (wr_ok && ADDRESS == 9'h1A8 |=> BOOST_ENABLE == !$past(WRITEDATA[7]))
    else $error("boost enable wrong");
  a_term_thresh: assert property (s_ctrl_wr ##1 1'b1 |=>
    TERM_THRESH_MV == ({7'h00, $past(WRITEDATA[3:0], 2)} * 11'd30) << THRESH_SCALE)
    else $error("terminal threshold wrong");
  a_avg_half: assert property (s_done ##0 avg_r[7:6] == 2'b01 |=>
    GEN_AVG == 12'(({1'b0, $past(GEN_AVG)} + $past(GEN_LEVEL)) >> 1))
    else $error("half average wrong");
  a_avg_qtr: assert property (s_done ##0 avg_r[7:6] == 2'b10 |=>
    GEN_AVG == 12'((3*$past(GEN_AVG) + $past(GEN_LEVEL)) >> 2))
    else $error("quarter avg wrong");
  a_load_raw: assert property (s_done ##0 avg_r[5] |=> LOAD_AVG == $past(LOAD_LEVEL))
    else $error("load average not bypassed");
  a_temp_raw: assert property (s_done ##0 avg_r[4] |=> TEMP_AVG == $past(TEMP_LEVEL))
    else $error("temperature average not bypassed");
endmodule // ifsc_top_asserts
bind ifsc_top ifsc_top_asserts ifsc_top_asserts_inst (.*);

//--- bench/ifsc_scan_model.sv
// Purpose: behavioural analog scan front end
// Assumes: one SCAN_DONE for each SCAN_START
// Notes:   outside the done cycle the data lines show inverted values
`timescale 1ns/1ps
module ifsc_scan_model (
  input  wire logic        CLK,          // clock
  input  wire logic        RESETN,       // reset, active low
  input  wire logic        SCAN_START,   // scan kick
  input  wire logic [7:0]  DELAY,        // answer delay, at least 1
  input  wire logic [4:0]  DET,          // detections to report
  input  wire logic [11:0] LVL,          // level to report
  output logic             SCAN_DONE,    // scan end pulse
  output logic      [4:0]  FAULT_DETECT, // raw detections
  output logic      [11:0] LEVEL         // reported level
);
  logic [7:0] cnt_r;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r     <= 8'h00;
      SCAN_DONE <= 1'b0;
    end else begin
      SCAN_DONE <= (cnt_r == 8'h01);
      cnt_r     <= SCAN_START ? DELAY : cnt_r - {7'h00, cnt_r != 8'h00};
    end
  end
  // stale data is never left looking valid
  assign FAULT_DETECT = SCAN_DONE ? DET : ~DET;
  assign LEVEL        = SCAN_DONE ? LVL : ~LVL;
endmodule // ifsc_scan_model

//--- bench/test_ifsc_top.sv
// Purpose: self-checking bench of the fault scan configuration block
// Assumes: scan intervals shortened to 20, 80 and 160 cycles
// Notes:   read data is checked against a queue of expectations
`timescale 1ns/1ps
module test_ifsc_top;
  localparam int IA = 20;
  localparam int IB = 80;
  localparam int IC = 160;
  logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, vbat = 1'b0;
  logic [8:0]  addr = 9'h000;
  logic [7:0]  wdat = 8'h00, dly = 8'h03, sp;
  logic [4:0]  det = 5'h00, dt, flags;
  logic [11:0] lvl = 12'h000, lev;
  logic [31:0] rdat;
  logic [10:0] thr;
  logic        wq, irq, st, dn, sc, bst;
  logic [15:0] lf = 16'h342A;
  logic [31:0] q[$];
  int          err_total = 0, checked = 0, cyc = 0;
  int          lim[6] = '{16, 8, 4, 1, 16, 8};

  ifsc_top #(.INTERVAL_A(IA), .INTERVAL_B(IB), .INTERVAL_C(IC)) ifsc_top_inst (
    .CLK(clk), .RESETN(resetn), .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA({24'h0, wdat}),
    .BYTEENABLE(4'hF), .READDATA(rdat), .WAITREQUEST(wq), .IRQ(irq), .SCAN_START(st), .SCAN_DONE(dn),
    .FAULT_DETECT(dt), .VBAT_BELOW_BIAS(vbat), .GEN_LEVEL(lev), .LOAD_LEVEL(lev), .TEMP_LEVEL(lev),
    .GEN_AVG(), .LOAD_AVG(), .TEMP_AVG(), .FAULT_FLAGS(flags), .TERM_THRESH_MV(thr),
    .THRESH_SCALE(sc), .BOOST_ENABLE(bst), .SIGPATH_CFG(sp));
  ifsc_scan_model ifsc_scan_model_inst (.CLK(clk), .RESETN(resetn), .SCAN_START(st), .DELAY(dly),
    .DET(det), .LVL(lvl), .SCAN_DONE(dn), .FAULT_DETECT(dt), .LEVEL(lev));

  always #50 clk = ~clk;
  // ==========
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rd && !wq) chk(rdat, q.pop_front(), "readback");
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  // ==========
  // bus and scan helpers
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic bus(input logic [8:0] a, input logic [7:0] d, input logic w);
    addr <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    @(posedge clk iff !wq);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdx(input logic [8:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(a, 8'h00, 1'b0);
  endtask
  task automatic scans(input int n);
    repeat (n) @(posedge clk iff dn);
    repeat (2) @(posedge clk);
  endtask
  task automatic gap(output int n);
    @(posedge clk iff st);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!st);
  endtask
  // ==========
  // main sequence
  initial begin
    logic [3:0] c;
    int         n;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdx(9'h19C, 8'hB8);
    rdx(9'h1A0, 8'h00);
    rdx(9'h1AC, 8'h01);
    chk(sp, 1, "sigpath");
    rdx(9'h19E, 8'h00);
    chk(thr, 90, "thr");
    bus(9'h1A8, 8'h80, 1'b1);
    chk(bst, 1'b0, "boost");
    bus(9'h1A8, 8'h00, 1'b1);
    chk(bst, 1'b1, "boost");
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      c = (i < 2) ? 4'hF : lf[3:0];
      bus(9'h19C, {7'b1011100, i[0]}, 1'b1);
      bus(9'h1F0, {4'h0, c}, 1'b1);
      @(posedge clk);
      chk(thr, (c * 30) << i[0], "thr");
    end
    bus(9'h1F0, 8'h80, 1'b1);
    for (int i = 0; i < 6; i++) begin
      det  <= 5'h00;
      vbat <= (i > 3);
      bus(9'h19C, {4'h3, (i > 3) ? 2'b11 : i[1:0], i == 5, 1'b0}, 1'b1);
      scans(1);
      det <= 5'h1F;
      scans(lim[i] - 1);
      chk(flags[i < 4], 1'b0, "flag");
      scans(1);
      chk(flags[i < 4], 1'b1, "flag");
    end
    det <= 5'h00;
    for (int k = 1; k < 4; k++) begin
      bus(9'h19C, {k[1:0], 6'h38}, 1'b1);
      gap(n);
      gap(n);
      chk(n, (k == 1) ? IA : ((k == 2) ? IB : IC), "gap");
    end
    lf = nx(lf);
    dly <= {5'h00, lf[2:0]} + 8'h02;
    bus(9'h19C, 8'h38, 1'b1);
    gap(n);
    gap(n);
    chk(n, lf[2:0] + 4, "gap");
    bus(9'h19C, 8'hB8, 1'b1);
    for (int m = 1; m < 3; m++) begin
      bus(9'h1A0, {m[1:0], 6'h30}, 1'b1);
      rdx(9'h1A0, {m[1:0], 6'h30});
      repeat (3) begin
        lf = nx(lf);
        lvl <= lf[11:0];
        scans(1);
      end
    end
    @(posedge clk iff dn);
    chk(irq, 1'b0, "irq");
    bus(9'h1F8, 8'hFF, 1'b1);
    bus(9'h1FC, 8'h20, 1'b1);
    chk(irq, 1'b0, "irq");
    scans(1);
    chk(irq, 1'b1, "irq");
    rdx(9'h1F8, 8'h20);
    bus(9'h1F8, 8'h20, 1'b1);
    chk(irq, 1'b0, "irq");
    end_sim;
  end
endmodule // test_ifsc_top
